/* hdl/ata_wr_consts.svh */
// Purpose: command codes, error codes and counts for the write/standby decoder
// Assumes: 100 MHz system clock
// Notes: definitions only
`ifndef ATA_WR_CONSTS_SVH
`define ATA_WR_CONSTS_SVH
`define CMD_STANDBY_IMM 8'hE0
`define CMD_STANDBY 8'hE2
`define CMD_WRITE_BUF 8'hE8
`define CMD_WR_DMA_A 8'hCA
`define CMD_WR_DMA_B 8'hCB
`define CMD_WR_DMA_EXT 8'h35
`define CMD_WR_MULT 8'hC5
`define CMD_WR_MULT_EXT 8'h39
`define CMD_WR_SECT 8'h30
`define CMD_WR_SECT_EXT 8'h34
`define CMD_WR_NOERASE 8'h38
`define CMD_WR_VERIFY 8'h3C
`define CMD_SET_MULT 8'hC6
`define CMD_SET_MAX 8'hF9
`define CMD_SET_MAX_EXT 8'h37
`define ERR_ABORT 8'h04
`define ERR_IDNF 8'h10
`define ERR_NONE 8'h00
`define SECT_WORDS 16'h0100
`define MULT_DEFAULT 8'h01
`endif

/* hdl/ata_wr_pkg.sv */
// Purpose: types shared by the write/standby decoder
// Assumes: nothing
// Notes: Gray-coded state order along the verify path
package ata_wr_pkg;
	typedef enum logic [2:0] {
		ST_IDLE = 3'h0,
		ST_XFER = 3'h1,
		ST_VERIFY = 3'h3,
		ST_DONE = 3'h2,
		ST_BUFW = 3'h6
	} seq_state_t;
	typedef enum logic [2:0] {
		K_NONE = 3'h0,
		K_PIO = 3'h1,
		K_DMA = 3'h2,
		K_MULT = 3'h3,
		K_VERIFY = 3'h4
	} wr_kind_t;
endpackage

/* hdl/sector_word_counter.sv */
// Purpose: counts data words within one sector, pulses at sector end
// Assumes: one word accepted per strobe
// Notes: cleared at every command start
`timescale 1ns/10ps
`default_nettype none
module sector_word_counter #(
	parameter int WORDS = 256
) (
	input wire logic clk_sys_in, // System clock
	input wire logic rst_n_in, // Async reset, active low
	input wire logic clear_in, // Restart count
	input wire logic word_in, // Word accepted
	output logic sector_end_out // Last word of sector
);
	logic [15:0] count;
	// Refused at elaboration: the count register is 16 bits wide
	if (WORDS < 2 || WORDS > 65535) begin : g_bad_words
		$error("sector_word_counter: WORDS out of range");
	end
	assign sector_end_out = word_in && (count == 16'(WORDS - 1));
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count <= 16'h0000;
		end else if (clear_in || sector_end_out) begin
			count <= 16'h0000;
		end else if (word_in) begin
			count <= count + 16'h0001;
		end
	end
endmodule
`default_nettype wire

/* hdl/ata_write_standby_cmd_decoder.sv */
// Purpose: decodes standby, write-buffer, write and set commands; sequences sectors
// Assumes: host holds task-file values steady with cmd_valid_in pulse
// Notes: media and verify engines are outside; this block steps and reports
// Behaviour
// - Standby commands raise busy, enter standby, drop busy, interrupt at once.
// - Write-buffer command replaces the sector buffer with host data.
// - CAh/CBh write 1..256 sectors by DMA; zero count means 256.
// - 35h writes 1..65536 sectors by DMA; zero count means 65536.
// - Transfer starts at the sector number the host loaded.
// - Multiple writes interrupt once per block of set-multiple sectors.
// - 30h writes 1..256 sectors by programmed transfer; zero means 256.
// - 34h writes 1..65536 sectors by programmed transfer; zero means 65536.
// - 38h writes 1..256 sectors; zero count means 256.
// - 3Ch verifies every written sector before reporting completion.
// - After a max-address limit is set, writes beyond it fail ID-not-found.
// - Set-multiple enables multiple commands and stores their block size.
`timescale 1ns/10ps
`default_nettype none
`include "ata_wr_consts.svh"
module ata_write_standby_cmd_decoder #(
	parameter int LBA_W = 48,
	parameter int BUF_WORDS = 256,
	parameter int VERIFY_CYCLES = 4
) (
	input wire logic clk_sys_in, // System clock
	input wire logic rst_n_in, // Async reset, active low
	input wire logic cmd_valid_in, // Command register written
	input wire logic [7:0] cmd_code_in, // Command code
	input wire logic [15:0] sect_count_in, // Sector count, 16 bits for ext
	input wire logic [LBA_W-1:0] sect_num_in, // Starting sector / new limit
	input wire logic data_valid_in, // Host data word present
	input wire logic [15:0] data_in, // Host data word
	input wire logic verify_ok_in, // Media verify of current sector done
	output logic busy_out, // Busy status
	output logic drq_out, // Ready for PIO data
	output logic dma_req_out, // Ready for DMA data
	output logic intrq_out, // Interrupt pulse
	output logic standby_out, // Standby power state
	output logic [7:0] error_out, // Error register
	output logic err_out, // Error status bit
	output logic wr_en_out, // Media word write strobe
	output logic [LBA_W-1:0] wr_lba_out, // Sector being written
	output logic [15:0] wr_data_out, // Media word
	output logic [7:0] buf_rd_data_out // Low byte of sector buffer word at write address
);
	import ata_wr_pkg::*;
	localparam int AW = $clog2(BUF_WORDS);
	// Refused at elaboration: limit compare and buffer address need these
	if (LBA_W < 28 || BUF_WORDS < 2 || VERIFY_CYCLES < 1) begin : g_bad_param
		$error("ata_write_standby_cmd_decoder: bad parameter");
	end

	// Zero count means the maximum for the command width
	function automatic logic [16:0] decode_count(input logic [15:0] cnt, input logic ext);
		logic [16:0] r;
		r = ext ? {1'b0, cnt} : {9'h000, cnt[7:0]};
		if (r == 17'h00000) begin
			r = ext ? 17'h10000 : 17'h00100;
		end
		return r;
	endfunction

	seq_state_t state;
	wr_kind_t kind;
	logic [16:0] remaining;
	logic [7:0] mult_size;
	logic mult_enabled;
	logic [7:0] blk_left;
	logic [LBA_W-1:0] max_lba;
	logic limit_set;
	logic [LBA_W-1:0] cur_lba;
	logic [AW-1:0] buf_addr;
	logic [15:0] sbuf [0:BUF_WORDS-1];
	logic word_take;
	logic sector_end;
	logic [16:0] nsect;
	logic is_ext;

	assign word_take = data_valid_in && (drq_out || dma_req_out);
	assign is_ext = (cmd_code_in == `CMD_WR_DMA_EXT) || (cmd_code_in == `CMD_WR_SECT_EXT)
		|| (cmd_code_in == `CMD_WR_MULT_EXT);
	assign nsect = decode_count(sect_count_in, is_ext);

	sector_word_counter #(.WORDS(`SECT_WORDS)) u_cnt (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.clear_in(cmd_valid_in && state == ST_IDLE),
		.word_in(word_take && state == ST_XFER),
		.sector_end_out(sector_end)
	);

	// Command acceptance and sequencing
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			state <= ST_IDLE;
			kind <= K_NONE;
			remaining <= 17'h00000;
			blk_left <= 8'h00;
			busy_out <= 1'b0;
			drq_out <= 1'b0;
			dma_req_out <= 1'b0;
			intrq_out <= 1'b0;
			standby_out <= 1'b0;
			error_out <= `ERR_NONE;
			err_out <= 1'b0;
			cur_lba <= '0;
			mult_size <= `MULT_DEFAULT;
			mult_enabled <= 1'b0;
			max_lba <= '0;
			limit_set <= 1'b0;
		end else begin
			intrq_out <= 1'b0;
			case (state)
			ST_IDLE: begin
				if (cmd_valid_in) begin
					error_out <= `ERR_NONE;
					err_out <= 1'b0;
					case (cmd_code_in)
					`CMD_STANDBY, `CMD_STANDBY_IMM: begin
						// Power change is immediate, so busy spans one cycle
						standby_out <= 1'b1;
						busy_out <= 1'b1;
						state <= ST_DONE;
					end
					`CMD_WRITE_BUF: begin
						busy_out <= 1'b0;
						drq_out <= 1'b1;
						state <= ST_BUFW;
					end
					`CMD_SET_MULT: begin
						if (sect_count_in[7:0] == 8'h00) begin
							error_out <= `ERR_ABORT;
							err_out <= 1'b1;
						end else begin
							mult_size <= sect_count_in[7:0];
							mult_enabled <= 1'b1;
						end
						busy_out <= 1'b1;
						state <= ST_DONE;
					end
					`CMD_SET_MAX, `CMD_SET_MAX_EXT: begin
						max_lba <= sect_num_in;
						limit_set <= 1'b1;
						busy_out <= 1'b1;
						state <= ST_DONE;
					end
					`CMD_WR_DMA_A, `CMD_WR_DMA_B, `CMD_WR_DMA_EXT, `CMD_WR_SECT,
					`CMD_WR_SECT_EXT, `CMD_WR_NOERASE, `CMD_WR_VERIFY,
					`CMD_WR_MULT, `CMD_WR_MULT_EXT: begin
						standby_out <= 1'b0;
						if ((cmd_code_in == `CMD_WR_MULT || cmd_code_in == `CMD_WR_MULT_EXT)
							&& !mult_enabled) begin
							error_out <= `ERR_ABORT;
							err_out <= 1'b1;
							busy_out <= 1'b1;
							state <= ST_DONE;
						end else if (limit_set && ({7'h00, sect_num_in} + (LBA_W+7)'(nsect)
							- (LBA_W+7)'(1)) > {7'h00, max_lba}) begin
							error_out <= `ERR_IDNF;
							err_out <= 1'b1;
							busy_out <= 1'b1;
							state <= ST_DONE;
						end else begin
							remaining <= nsect;
							cur_lba <= sect_num_in;
							blk_left <= mult_size;
							state <= ST_XFER;
							case (cmd_code_in)
							`CMD_WR_DMA_A, `CMD_WR_DMA_B, `CMD_WR_DMA_EXT: begin
								kind <= K_DMA;
								dma_req_out <= 1'b1;
							end
							`CMD_WR_MULT, `CMD_WR_MULT_EXT: begin
								kind <= K_MULT;
								drq_out <= 1'b1;
							end
							`CMD_WR_VERIFY: begin
								kind <= K_VERIFY;
								drq_out <= 1'b1;
							end
							default: begin
								kind <= K_PIO;
								drq_out <= 1'b1;
							end
							endcase
						end
					end
					default: begin
						error_out <= `ERR_ABORT;
						err_out <= 1'b1;
						busy_out <= 1'b1;
						state <= ST_DONE;
					end
					endcase
				end
			end
			ST_XFER: begin
				if (sector_end) begin
					cur_lba <= cur_lba + LBA_W'(1);
					remaining <= remaining - 17'h00001;
					blk_left <= (blk_left == 8'h01) ? mult_size : blk_left - 8'h01;
					if (kind == K_VERIFY) begin
						// Host held off until the sector is checked
						drq_out <= 1'b0;
						busy_out <= 1'b1;
						state <= ST_VERIFY;
					end else if (remaining == 17'h00001) begin
						drq_out <= 1'b0;
						dma_req_out <= 1'b0;
						busy_out <= 1'b1;
						state <= ST_DONE;
					end else if (kind == K_MULT) begin
						intrq_out <= (blk_left == 8'h01);
					end else if (kind == K_PIO) begin
						intrq_out <= 1'b1;
					end
				end
			end
			ST_VERIFY: begin
				if (verify_ok_in) begin
					if (remaining == 17'h00000) begin
						state <= ST_DONE;
					end else begin
						busy_out <= 1'b0;
						drq_out <= 1'b1;
						intrq_out <= 1'b1;
						state <= ST_XFER;
					end
				end
			end
			ST_BUFW: begin
				if (word_take && buf_addr == AW'(BUF_WORDS - 1)) begin
					drq_out <= 1'b0;
					busy_out <= 1'b1;
					state <= ST_DONE;
				end
			end
			ST_DONE: begin
				busy_out <= 1'b0;
				intrq_out <= 1'b1;
				kind <= K_NONE;
				state <= ST_IDLE;
			end
			default: begin
				state <= ST_IDLE;
			end
			endcase
		end
	end

	// Sector buffer fill; no reset on the array, it is data only
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			buf_addr <= '0;
		end else if (state == ST_IDLE) begin
			buf_addr <= '0;
		end else if (state == ST_BUFW && word_take) begin
			buf_addr <= buf_addr + AW'(1);
		end
	end

	always_ff @(posedge clk_sys_in) begin
		if (state == ST_BUFW && word_take) begin
			sbuf[buf_addr] <= data_in;
		end
	end

	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			buf_rd_data_out <= 8'h00;
		end else begin
			buf_rd_data_out <= sbuf[buf_addr][7:0];
		end
	end

	// Media write path
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			wr_en_out <= 1'b0;
			wr_data_out <= 16'h0000;
			wr_lba_out <= '0;
		end else begin
			wr_en_out <= word_take && state == ST_XFER;
			wr_data_out <= data_in;
			// Sector travels with its word, so a sector's last word keeps its address
			wr_lba_out <= cur_lba;
		end
	end
endmodule
`default_nettype wire

/* dv/ata_wr_monitor.sv */
// Purpose: port checks for the write/standby decoder
// Assumes: one clock, async active-low reset
// Notes: a command is taken only when fully idle
`timescale 1ns/10ps
`default_nettype none
`include "ata_wr_consts.svh"
module ata_wr_monitor (
	input wire logic clk_sys_in, // Clock
	input wire logic rst_n_in, // Reset
	input wire logic cmd_valid_in, // Strobe
	input wire logic [7:0] cmd_code_in, // Code
	input wire logic data_valid_in, // Word valid
	input wire logic [15:0] data_in, // Word
	input wire logic busy_out, // Busy
	input wire logic drq_out, // PIO req
	input wire logic dma_req_out, // DMA req
	input wire logic intrq_out, // Interrupt
	input wire logic standby_out, // Standby
	input wire logic [7:0] error_out, // Error
	input wire logic err_out, // Error bit
	input wire logic wr_en_out, // Media strobe
	input wire logic [15:0] wr_data_out // Media word
);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	logic req;
	logic tk;
	assign req = drq_out || dma_req_out;
	assign tk = cmd_valid_in && !busy_out && !req && !intrq_out;
	standby_entry_a: assert property (tk && cmd_code_in inside {8'hE0, 8'hE2} |=>
		busy_out && standby_out ##1 !busy_out && intrq_out) else $error("standby sequence");
	standby_exit_a: assert property ($fell(standby_out) |->
		$past(cmd_valid_in) || req || busy_out) else $error("standby dropped");
	unknown_abort_a: assert property (tk && cmd_code_in == 8'h00 |=>
		busy_out && !req ##1 intrq_out && err_out && error_out == `ERR_ABORT) else $error("abort");
	dma_start_a: assert property (tk && cmd_code_in inside {8'hCA, 8'hCB, 8'h35} |=>
		dma_req_out && !drq_out) else $error("dma start");
	pio_start_a: assert property (tk && cmd_code_in inside {8'h30, 8'h38, 8'h3C} |=>
		drq_out && !dma_req_out) else $error("pio start");
	media_word_a: assert property (wr_en_out |->
		$past(req && data_valid_in) && wr_data_out == $past(data_in)) else $error("word");
	intr_pulse_a: assert property (intrq_out |=> !intrq_out) else $error("intr width");
	dma_quiet_a: assert property (dma_req_out |-> !intrq_out) else $error("dma intr");
endmodule
`default_nettype wire

/* dv/host_link_model.sv */
// Purpose: host side: data words with random stalls, verify answers
// Assumes: a word is taken at an edge with request and valid high
// Notes: idle data changes only while invalid, then holds until taken
`timescale 1ns/10ps
`default_nettype none
module host_link_model (
	input wire logic clk_sys_in, // Clock
	input wire logic req_in, // Device wants data
	input wire logic vwait_in, // Device busy
	output logic data_valid_out, // Word present
	output logic [15:0] data_out, // Word
	output logic verify_ok_out // Verify passed
);
	initial begin
		data_valid_out = 1'b0;
		data_out = 16'h0000;
		verify_ok_out = 1'b0;
	end
	always @(posedge clk_sys_in) begin
		verify_ok_out <= #1 vwait_in && !verify_ok_out && $urandom_range(3) == 0;
		// Valid word held until taken
		if (req_in && data_valid_out || !data_valid_out) begin
			data_valid_out <= #1 $urandom_range(3) != 0;
			data_out <= #1 16'($urandom);
		end
	end
endmodule
`default_nettype wire

/* dv/tb_ata_write_standby_cmd_decoder.sv */
// Purpose: command-level bench for the write/standby decoder
// Assumes: no limit until the two set-max tests near the end set one
// Notes: media words checked against a queue of taken words
`timescale 1ns/10ps
`default_nettype none
`include "ata_wr_consts.svh"
module tb_ata_write_standby_cmd_decoder;
	logic clk_sys_in, rst_n_in, cmd_valid_in, data_valid_in, verify_ok_in, media;
	logic busy_out, drq_out, dma_req_out, intrq_out, standby_out, err_out, wr_en_out;
	logic [7:0] cmd_code_in, error_out, buf_rd_data_out, buf_first;
	logic [15:0] sect_count_in, data_in, wr_data_out;
	logic [47:0] sect_num_in, wr_lba_out, lba, s;
	logic [63:0] exp_q[$];
	int bad_count, cmp_count, n_intr, n_word, cycles;
	ata_write_standby_cmd_decoder dut (
		.clk_sys_in(clk_sys_in),
		.rst_n_in(rst_n_in),
		.cmd_valid_in(cmd_valid_in),
		.cmd_code_in(cmd_code_in),
		.sect_count_in(sect_count_in),
		.sect_num_in(sect_num_in),
		.data_valid_in(data_valid_in),
		.data_in(data_in),
		.verify_ok_in(verify_ok_in),
		.busy_out(busy_out),
		.drq_out(drq_out),
		.dma_req_out(dma_req_out),
		.intrq_out(intrq_out),
		.standby_out(standby_out),
		.error_out(error_out),
		.err_out(err_out),
		.wr_en_out(wr_en_out),
		.wr_lba_out(wr_lba_out),
		.wr_data_out(wr_data_out),
		.buf_rd_data_out(buf_rd_data_out)
	);
	host_link_model host (
		.clk_sys_in(clk_sys_in),
		.req_in(drq_out || dma_req_out),
		.vwait_in(busy_out),
		.data_valid_out(data_valid_in),
		.data_out(data_in),
		.verify_ok_out(verify_ok_in)
	);
	initial begin
		clk_sys_in = 1'b0;
		forever #5 clk_sys_in = ~clk_sys_in;
	end
	task automatic chk(input logic [63:0] got, input logic [63:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic run(input logic [7:0] code, input logic [15:0] cnt, input int n_exp,
		input logic [7:0] err_exp);
		int w;
		media = code != `CMD_WRITE_BUF;
		lba = s;
		n_word = 0;
		n_intr = 0;
		cmd_code_in = code;
		sect_count_in = cnt;
		sect_num_in = s;
		cmd_valid_in = 1'b1;
		@(posedge clk_sys_in) #1;
		cmd_valid_in = 1'b0;
		w = 0;
		while (!(n_intr >= n_exp && !busy_out && !drq_out && !dma_req_out) && w < 30000) begin
			@(posedge clk_sys_in) #1;
			w++;
		end
		repeat (2) @(posedge clk_sys_in);
		#1;
		chk(64'(w >= 30000), 64'h0000000000000000);
		chk(64'(n_intr), 64'(n_exp));
		chk(64'(error_out), 64'(err_exp));
		$display("test %h done", code);
	endtask
	always @(posedge clk_sys_in) begin
		cycles++;
		if (intrq_out === 1'b1) n_intr++;
		if (wr_en_out === 1'b1) chk({wr_lba_out, wr_data_out}, exp_q.pop_front());
		if ((drq_out || dma_req_out) && data_valid_in) begin
			if (media) exp_q.push_back({lba + 48'(n_word / 256), data_in});
			else if (n_word == 0) buf_first = data_in[7:0];
			n_word++;
		end
		// Ceiling far above the roughly 5.5k cycles the tests need
		if (cycles > 60000) begin
			bad_count++;
			final_report();
		end
	end
	initial begin
		void'($urandom(32'hEB589222));
		{rst_n_in, cmd_valid_in, media, cmd_code_in, sect_count_in, sect_num_in} = '0;
		s = 48'h000000000000;
		repeat (4) @(posedge clk_sys_in);
		#1 rst_n_in = 1'b1;
		run(`CMD_STANDBY, 16'h0000, 1, `ERR_NONE);
		run(`CMD_STANDBY_IMM, 16'h0000, 1, `ERR_NONE);
		run(8'h00, 16'h0001, 1, `ERR_ABORT);
		run(`CMD_WR_MULT, 16'h0003, 1, `ERR_ABORT);
		run(`CMD_SET_MULT, 16'h0000, 1, `ERR_ABORT);
		run(`CMD_SET_MULT, 16'h0002, 1, `ERR_NONE);
		s = 48'($urandom);
		run(`CMD_WR_MULT, 16'h0003, 2, `ERR_NONE);
		run(`CMD_WR_MULT_EXT, 16'h0002, 1, `ERR_NONE);
		run(`CMD_WR_SECT, 16'h0002, 2, `ERR_NONE);
		run(`CMD_WR_SECT_EXT, 16'h0001, 1, `ERR_NONE);
		run(`CMD_WR_NOERASE, 16'h0001, 1, `ERR_NONE);
		run(`CMD_WR_VERIFY, 16'h0002, 2, `ERR_NONE);
		s = 48'($urandom);
		run(`CMD_WR_DMA_A, 16'h0001, 1, `ERR_NONE);
		run(`CMD_WR_DMA_B, 16'h0001, 1, `ERR_NONE);
		run(`CMD_WR_DMA_EXT, 16'h0001, 1, `ERR_NONE);
		run(`CMD_WRITE_BUF, 16'h0001, 1, `ERR_NONE);
		chk(64'(n_word), 64'h0000000000000100);
		chk(64'(buf_rd_data_out), 64'(buf_first));
		run(`CMD_SET_MAX_EXT, 16'h0000, 1, `ERR_NONE);
		run(`CMD_SET_MAX, 16'h0000, 1, `ERR_NONE);
		run(`CMD_WR_SECT, 16'h0001, 1, `ERR_NONE);
		run(`CMD_WR_SECT_EXT, 16'h0002, 1, `ERR_IDNF);
		chk(64'(exp_q.size()), 64'h0000000000000000);
		final_report();
	end
endmodule
bind ata_write_standby_cmd_decoder ata_wr_monitor mon (
	.clk_sys_in(clk_sys_in),
	.rst_n_in(rst_n_in),
	.cmd_valid_in(cmd_valid_in),
	.cmd_code_in(cmd_code_in),
	.data_valid_in(data_valid_in),
	.data_in(data_in),
	.busy_out(busy_out),
	.drq_out(drq_out),
	.dma_req_out(dma_req_out),
	.intrq_out(intrq_out),
	.standby_out(standby_out),
	.error_out(error_out),
	.err_out(err_out),
	.wr_en_out(wr_en_out),
	.wr_data_out(wr_data_out)
);
`default_nettype wire
